// *** logic/sub_unit_pkg.sv ***
// Constants, field layouts and carrier types of the subtract unit.
// Assumes a single 10 MHz clock and a 32-bit Avalon-MM register port.
package sub_unit_pkg;

    // ------------------------------------------------------------
    // Widths and decimal limits
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int BCD_DIGITS = 8;
    localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
    localparam logic [3:0] BCD_RADIX = 4'hA;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [5:0] MIN_LO_OFS = 6'h00;
    localparam logic [5:0] MIN_HI_OFS = 6'h04;
    localparam logic [5:0] SUB_LO_OFS = 6'h08;
    localparam logic [5:0] SUB_HI_OFS = 6'h0C;
    localparam logic [5:0] CTRL_OFS = 6'h10;
    localparam logic [5:0] RES_LO_OFS = 6'h14;
    localparam logic [5:0] RES_HI_OFS = 6'h18;
    localparam logic [5:0] FLAGS_OFS = 6'h1C;
    localparam logic [5:0] EXEC_CNT_OFS = 6'h20;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_COND_BIT = 2;
    localparam int CTRL_EDGE_BIT = 3;
    localparam int CTRL_W = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
    localparam logic [15:0] EXEC_CNT_RESET = 16'h0000;
    localparam logic [31:0] RDATA_RESET = 32'h00000000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_SIGNED_BORROW = 2'h0,
        OP_BCD_WORD = 2'h1,
        OP_BCD_DOUBLE = 2'h2,
        OP_CLEAR_BORROW = 2'h3
    } op_t;

    typedef struct packed {
        logic sign;
        logic underflow;
        logic overflow;
        logic borrow;
        logic zero;
        logic error;
    } flags_t;

    localparam flags_t FLAGS_RESET = 6'h00;

endpackage

// *** logic/bcd_digit_sub.sv ***
// One decimal digit of a BCD subtractor with borrow in and out.
// Assumes pure combinational use inside a ripple chain.
`timescale 1ns/1ns
module bcd_digit_sub (
    input wire logic [3:0] min_digit,
    input wire logic [3:0] sub_digit,
    input wire logic borrow_in,
    output logic [3:0] diff_digit,
    output logic borrow_out,
    output logic bad_digit
);
    wire logic [4:0] raw_diff;

    assign raw_diff = {1'b0, min_digit} - {1'b0, sub_digit} - {4'h0, borrow_in};
    assign borrow_out = raw_diff[4];
    // A negative digit wraps by adding the radix, which yields the ten's complement
    assign diff_digit = raw_diff[4] ? 4'(raw_diff[3:0] + sub_unit_pkg::BCD_RADIX)
                                    : raw_diff[3:0];
    assign bad_digit = (min_digit > sub_unit_pkg::BCD_MAX_DIGIT)
                     | (sub_digit > sub_unit_pkg::BCD_MAX_DIGIT);
endmodule // bcd_digit_sub

// *** logic/exec_trigger.sv ***
// Turns the execution condition into execute pulses.
// Assumes the condition comes from logic on the same clock.
`timescale 1ns/1ns
module exec_trigger (
    input wire logic clk,
    input wire logic rst,
    input wire logic cond,
    input wire logic edge_mode,
    output logic fire
);
    logic cond_prev_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            cond_prev_reg <= 1'b0;
        end else begin
            cond_prev_reg <= cond;
        end
    end

    // Level mode runs every cycle; edge mode only on a rising condition
    assign fire = cond & (~edge_mode | ~cond_prev_reg);
endmodule // exec_trigger

// *** logic/sub_unit.sv ***
// Subtract unit: signed double subtract with borrow, 4-digit and 8-digit BCD subtract.
// Assumes one clock, a synchronous reset and an Avalon-MM master on the register port.
//
// Overview of operation
// - Signed borrow subtract always clears the error flag.
// - Signed subtract: minuend minus subtrahend minus borrow into two result words.
// - Signed subtract sets zero when the 32-bit result is all zero.
// - Signed subtract sets borrow when a borrow leaves the top bit.
// - Overflow: positive minus negative and borrow gives a negative result.
// - Underflow: negative minus positive and borrow gives a positive result.
// - Signed subtract copies the top result bit into the sign flag.
// - A clear-borrow operation clears the borrow flag; software issues it as needed.
// - Negative binary results are held in two's complement.
// - Single-word BCD subtract writes a 4-digit result, ten's complement if negative.
// - Single-word BCD subtract flags error on any non-decimal nibble in the two low operand words.
// - Single-word BCD subtract sets zero when the result word is zero.
// - BCD subtracts without an error set borrow when the top digit borrows, else clear it; on an error borrow is held.
// - Double BCD subtract writes an 8-digit result, ten's complement if negative.
// - Double BCD subtract flags error on any non-decimal nibble in four words.
// - Double BCD subtract sets zero when both result words are zero.
// - Negative decimal results are nines' complement plus one.
// - Execute every cycle while condition is on, or once on its rising edge.
`timescale 1ns/1ns
module sub_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output sub_unit_pkg::flags_t flags_out,
    output logic [31:0] result_out
);
    localparam int W = sub_unit_pkg::WORD_W;
    localparam int ND = sub_unit_pkg::BCD_DIGITS;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [W-1:0] min_lo_reg, min_hi_reg, sub_lo_reg, sub_hi_reg;
    logic [W-1:0] res_lo_reg, res_hi_reg;
    logic [sub_unit_pkg::CTRL_W-1:0] ctrl_reg;
    sub_unit_pkg::flags_t flags_reg, flags_next;
    logic [W-1:0] res_lo_next, res_hi_next;
    logic [15:0] exec_cnt_reg;
    logic [31:0] rdata_reg;
    logic wait_reg;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic wr_take = avs_write & ~wait_reg;
    wire logic rd_answer = (avs_read | avs_write) & wait_reg;
    wire logic wr_min_lo = wr_take & (avs_address == sub_unit_pkg::MIN_LO_OFS);
    wire logic wr_min_hi = wr_take & (avs_address == sub_unit_pkg::MIN_HI_OFS);
    wire logic wr_sub_lo = wr_take & (avs_address == sub_unit_pkg::SUB_LO_OFS);
    wire logic wr_sub_hi = wr_take & (avs_address == sub_unit_pkg::SUB_HI_OFS);
    wire logic wr_ctrl = wr_take & (avs_address == sub_unit_pkg::CTRL_OFS);
    wire logic wr_flags = wr_take & (avs_address == sub_unit_pkg::FLAGS_OFS);
    wire logic [W-1:0] wdata16;
    wire logic [W-1:0] lane_mask;

    assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wdata16 = avs_writedata[W-1:0];

    function automatic logic [W-1:0] merge16(input logic [W-1:0] old_val,
                                             input logic [W-1:0] new_val,
                                             input logic [W-1:0] mask);
        merge16 = (old_val & ~mask) | (new_val & mask);
    endfunction

    wire logic [W-1:0] flags_merge = merge16({10'h000, flags_reg}, wdata16, lane_mask);

    // ------------------------------------------------------------
    // Execution trigger
    // ------------------------------------------------------------
    wire logic fire;
    wire sub_unit_pkg::op_t op;

    assign op = sub_unit_pkg::op_t'(ctrl_reg[sub_unit_pkg::CTRL_OP_LSB +: 2]);

    exec_trigger trig_u (
        .clk(clk),
        .rst(rst),
        .cond(ctrl_reg[sub_unit_pkg::CTRL_COND_BIT]),
        .edge_mode(ctrl_reg[sub_unit_pkg::CTRL_EDGE_BIT]),
        .fire(fire)
    );

    // ------------------------------------------------------------
    // Signed binary datapath
    // ------------------------------------------------------------
    wire logic [31:0] mi32 = {min_hi_reg, min_lo_reg};
    wire logic [31:0] su32 = {sub_hi_reg, sub_lo_reg};
    wire logic [32:0] bin_full;
    wire logic [31:0] bin_res;

    // Two's complement falls out of the modular subtract
    assign bin_full = {1'b0, mi32} - {1'b0, su32} - {32'h0, flags_reg.borrow};
    assign bin_res = bin_full[31:0];
    wire logic bin_zero = (bin_res == 32'h00000000);
    wire logic bin_borrow = bin_full[32];
    wire logic bin_ovf = ~mi32[31] & su32[31] & bin_res[31];
    wire logic bin_udf = mi32[31] & ~su32[31] & ~bin_res[31];

    // ------------------------------------------------------------
    // BCD datapath
    // ------------------------------------------------------------
    wire logic [ND:0] bcd_chain;
    wire logic [ND-1:0] bcd_bad;
    wire logic [31:0] bcd_res;

    assign bcd_chain[0] = 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < ND; gi++) begin : g_digit
            bcd_digit_sub dig_u (
                .min_digit(mi32[4*gi +: 4]),
                .sub_digit(su32[4*gi +: 4]),
                .borrow_in(bcd_chain[gi]),
                .diff_digit(bcd_res[4*gi +: 4]),
                .borrow_out(bcd_chain[gi+1]),
                .bad_digit(bcd_bad[gi])
            );
        end
    endgenerate

    wire logic bcd_w_err = |bcd_bad[ND/2-1:0];
    wire logic bcd_d_err = |bcd_bad;
    wire logic bcd_w_borrow = bcd_chain[ND/2];
    wire logic bcd_d_borrow = bcd_chain[ND];
    wire logic bcd_w_zero = (bcd_res[W-1:0] == 16'h0000);
    wire logic bcd_d_zero = (bcd_res == 32'h00000000);

    // ------------------------------------------------------------
    // Result and flag selection
    // ------------------------------------------------------------
    always_comb begin
        flags_next = flags_reg;
        res_lo_next = res_lo_reg;
        res_hi_next = res_hi_reg;
        if (fire) begin
            unique case (op)
                sub_unit_pkg::OP_SIGNED_BORROW: begin
                    res_lo_next = bin_res[W-1:0];
                    res_hi_next = bin_res[31:W];
                    flags_next.error = 1'b0;
                    flags_next.zero = bin_zero;
                    flags_next.borrow = bin_borrow;
                    flags_next.overflow = bin_ovf;
                    flags_next.underflow = bin_udf;
                    flags_next.sign = bin_res[31];
                end
                sub_unit_pkg::OP_BCD_WORD: begin
                    flags_next.error = bcd_w_err;
                    if (!bcd_w_err) begin
                        res_lo_next = bcd_res[W-1:0];
                        flags_next.zero = bcd_w_zero;
                        flags_next.borrow = bcd_w_borrow;
                    end
                end
                sub_unit_pkg::OP_BCD_DOUBLE: begin
                    flags_next.error = bcd_d_err;
                    if (!bcd_d_err) begin
                        res_lo_next = bcd_res[W-1:0];
                        res_hi_next = bcd_res[31:W];
                        flags_next.zero = bcd_d_zero;
                        flags_next.borrow = bcd_d_borrow;
                    end
                end
                sub_unit_pkg::OP_CLEAR_BORROW: begin
                    flags_next.borrow = 1'b0;
                end
            endcase
        end else if (wr_flags) begin
            // An execution in the same cycle wins over a software write
            flags_next = sub_unit_pkg::flags_t'(flags_merge[5:0]);
        end
    end

    // ------------------------------------------------------------
    // Operand and control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            min_lo_reg <= sub_unit_pkg::WORD_RESET;
            min_hi_reg <= sub_unit_pkg::WORD_RESET;
            sub_lo_reg <= sub_unit_pkg::WORD_RESET;
            sub_hi_reg <= sub_unit_pkg::WORD_RESET;
            ctrl_reg <= sub_unit_pkg::CTRL_RESET;
        end else begin
            if (wr_min_lo) min_lo_reg <= merge16(min_lo_reg, wdata16, lane_mask);
            if (wr_min_hi) min_hi_reg <= merge16(min_hi_reg, wdata16, lane_mask);
            if (wr_sub_lo) sub_lo_reg <= merge16(sub_lo_reg, wdata16, lane_mask);
            if (wr_sub_hi) sub_hi_reg <= merge16(sub_hi_reg, wdata16, lane_mask);
            if (wr_ctrl && avs_byteenable[0]) ctrl_reg <= avs_writedata[3:0];
        end
    end

    // ------------------------------------------------------------
    // Results and flags, all in one edge
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            res_lo_reg <= sub_unit_pkg::WORD_RESET;
            res_hi_reg <= sub_unit_pkg::WORD_RESET;
            flags_reg <= sub_unit_pkg::FLAGS_RESET;
            flags_out <= sub_unit_pkg::FLAGS_RESET;
            result_out <= 32'h00000000;
            exec_cnt_reg <= sub_unit_pkg::EXEC_CNT_RESET;
        end else begin
            res_lo_reg <= res_lo_next;
            res_hi_reg <= res_hi_next;
            flags_reg <= flags_next;
            flags_out <= flags_next;
            result_out <= {res_hi_next, res_lo_next};
            if (fire) exec_cnt_reg <= 16'(exec_cnt_reg + 16'h0001);
        end
    end

    // ------------------------------------------------------------
    // Avalon answer: one wait cycle, then read data with waitrequest low
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        unique case (avs_address)
            sub_unit_pkg::MIN_LO_OFS: rd_mux = {16'h0000, min_lo_reg};
            sub_unit_pkg::MIN_HI_OFS: rd_mux = {16'h0000, min_hi_reg};
            sub_unit_pkg::SUB_LO_OFS: rd_mux = {16'h0000, sub_lo_reg};
            sub_unit_pkg::SUB_HI_OFS: rd_mux = {16'h0000, sub_hi_reg};
            sub_unit_pkg::CTRL_OFS: rd_mux = {28'h0000000, ctrl_reg};
            sub_unit_pkg::RES_LO_OFS: rd_mux = {16'h0000, res_lo_reg};
            sub_unit_pkg::RES_HI_OFS: rd_mux = {16'h0000, res_hi_reg};
            sub_unit_pkg::FLAGS_OFS: rd_mux = {26'h0000000, flags_reg};
            sub_unit_pkg::EXEC_CNT_OFS: rd_mux = {16'h0000, exec_cnt_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_reg <= 1'b1;
            rdata_reg <= sub_unit_pkg::RDATA_RESET;
        end else begin
            wait_reg <= ~rd_answer;
            if (rd_answer && avs_read) rdata_reg <= rd_mux;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    wire logic sig_fire = fire & (op == sub_unit_pkg::OP_SIGNED_BORROW);
    wire logic bw_fire = fire & (op == sub_unit_pkg::OP_BCD_WORD);
    wire logic bd_fire = fire & (op == sub_unit_pkg::OP_BCD_DOUBLE);

    err_clear_a: assert property (@(posedge clk) disable iff (rst)
        sig_fire |=> !flags_reg.error) else $error("error flag not cleared");
    sig_result_a: assert property (@(posedge clk) disable iff (rst)
        sig_fire |=> {res_hi_reg, res_lo_reg} ==
            32'($past(mi32) - $past(su32) - {31'h0, $past(flags_reg.borrow)}))
        else $error("signed difference wrong");
    sig_zero_a: assert property (@(posedge clk) disable iff (rst)
        sig_fire |=> flags_reg.zero == ({res_hi_reg, res_lo_reg} == 32'h00000000))
        else $error("zero flag wrong");
    sig_borrow_a: assert property (@(posedge clk) disable iff (rst)
        sig_fire |=> flags_reg.borrow ==
            ({1'b0, $past(mi32)} < {1'b0, $past(su32)} + {32'h0, $past(flags_reg.borrow)}))
        else $error("borrow flag wrong");
    sig_ovf_a: assert property (@(posedge clk) disable iff (rst)
        sig_fire |=> flags_reg.overflow ==
            (!$past(mi32[31]) && $past(su32[31]) && res_hi_reg[15]))
        else $error("overflow flag wrong");
    sig_udf_a: assert property (@(posedge clk) disable iff (rst)
        sig_fire |=> flags_reg.underflow ==
            ($past(mi32[31]) && !$past(su32[31]) && !res_hi_reg[15]))
        else $error("underflow flag wrong");
    sig_sign_a: assert property (@(posedge clk) disable iff (rst)
        sig_fire |=> flags_reg.sign == res_hi_reg[15]) else $error("sign flag wrong");
    clr_borrow_a: assert property (@(posedge clk) disable iff (rst)
        fire && op == sub_unit_pkg::OP_CLEAR_BORROW |=> !flags_reg.borrow)
        else $error("borrow not cleared");
    bcd_hold_a: assert property (@(posedge clk) disable iff (rst)
        (bw_fire && bcd_w_err) || (bd_fire && bcd_d_err) |=>
            flags_reg.error && $stable(res_lo_reg) && $stable(res_hi_reg)
            && $stable(flags_reg.borrow)) else $error("error case wrote result");
    bcd_word_a: assert property (@(posedge clk) disable iff (rst)
        bw_fire && !bcd_w_err |=> !flags_reg.error && $stable(res_hi_reg)
            && flags_reg.zero == (res_lo_reg == 16'h0000))
        else $error("bcd word result wrong");
    edge_once_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_reg[sub_unit_pkg::CTRL_EDGE_BIT] && fire |=> !fire)
        else $error("edge mode fired twice");
    bus_wait_a: assert property (@(posedge clk) disable iff (rst)
        avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read answer late");

    // ------------------------------------------------------------
    // Further guards on bus timing, execution and decimal flags
    // ------------------------------------------------------------
    wait_pulse_a: assert property (@(posedge clk) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");

    write_lands_a: assert property (@(posedge clk) disable iff (rst)
        avs_write && !avs_waitrequest && avs_address == sub_unit_pkg::MIN_LO_OFS
            && avs_byteenable[1:0] == 2'b11 |=> min_lo_reg == $past(avs_writedata[15:0]))
        else $error("operand write lost");

    level_fire_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_reg[sub_unit_pkg::CTRL_COND_BIT] && !ctrl_reg[sub_unit_pkg::CTRL_EDGE_BIT]
            |-> fire)
        else $error("level mode missed a cycle");

    cond_off_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl_reg[sub_unit_pkg::CTRL_COND_BIT] |-> !fire)
        else $error("fired without condition");

    bcd_wborrow_a: assert property (@(posedge clk) disable iff (rst)
        bw_fire && !bcd_w_err |=>
            flags_reg.borrow == ($past(mi32[15:0]) < $past(su32[15:0])))
        else $error("bcd word borrow wrong");

    bcd_dbl_a: assert property (@(posedge clk) disable iff (rst)
        bd_fire && !bcd_d_err |=> !flags_reg.error
            && flags_reg.zero == ({res_hi_reg, res_lo_reg} == 32'h00000000))
        else $error("bcd double flags wrong");

    bcd_dborrow_a: assert property (@(posedge clk) disable iff (rst)
        bd_fire && !bcd_d_err |=>
            flags_reg.borrow == ($past(mi32) < $past(su32)))
        else $error("bcd double borrow wrong");

    out_match_a: assert property (@(posedge clk) disable iff (rst)
        flags_out == flags_reg && result_out == {res_hi_reg, res_lo_reg})
        else $error("output ports disagree");

    bcd_top_err_a: assert property (@(posedge clk) disable iff (rst)
        bd_fire && (mi32[31:28] > 4'h9 || su32[31:28] > 4'h9) |=> flags_reg.error)
        else $error("bad top digit not flagged");

    bcd_word_err_a: assert property (@(posedge clk) disable iff (rst)
        bw_fire && (mi32[7:4] > 4'h9 || su32[7:4] > 4'h9) |=> flags_reg.error)
        else $error("bad word digit not flagged");

endmodule // sub_unit

// *** tb/seq_model.sv ***
// Bus master standing in for the instruction sequencer of the subtract unit.
// Assumes an Avalon-MM slave with waitrequest on the same clock.
`timescale 1ns/1ns
module seq_model (
    input wire logic clk,
    output logic [5:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
    end

    // One transfer: hold the request until waitrequest is seen low
    task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= ~d;
    endtask
endmodule // seq_model

// *** tb/testbench.sv ***
// Self-checking bench for the subtract unit.
// Assumes seq_model as bus master; the unit answers after one wait cycle.
`timescale 1ns/1ns
module testbench;
    logic clk, rst;
    logic [5:0] adr;
    logic rd, wr, wt;
    logic [31:0] wd, rdt, res;
    logic [3:0] be;
    sub_unit_pkg::flags_t fo;
    int failures = 0, tests_run = 0, cycles = 0;
    logic [15:0] exp_lo = 16'h0, exp_hi = 16'h0, exp_cnt = 16'h0;
    logic [5:0] exp_fl;
    logic [31:0] g_lo, g_hi, g_fl, g_cnt;

    sub_unit dut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdt), .avs_waitrequest(wt),
        .flags_out(fo), .result_out(res));
    seq_model m (.clk(clk), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdt), .avs_waitrequest(wt));

    initial clk = 1'b0;
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            failures++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    function automatic longint dec(input logic [31:0] v, input int n);
        longint s;
        s = 0;
        for (int i = n - 1; i >= 0; i--) s = s * 10 + v[4*i+:4];
        return s;
    endfunction

    function automatic logic [31:0] bcd(input longint v);
        logic [31:0] r;
        for (int i = 0; i < 8; i++) begin
            r[4*i+:4] = 4'(v % 10);
            v = v / 10;
        end
        return r;
    endfunction

    // ----------------------------------------
    // Load operands, execute, read back
    // ----------------------------------------
    task automatic run(input logic [1:0] op, input logic [31:0] mi, input logic [31:0] su,
                       input logic [5:0] fl, input logic edg);
        logic [31:0] q;
        m.xfer(1'b0, sub_unit_pkg::MIN_LO_OFS, {16'h0, mi[15:0]}, q);
        m.xfer(1'b0, sub_unit_pkg::MIN_HI_OFS, {16'h0, mi[31:16]}, q);
        m.xfer(1'b0, sub_unit_pkg::SUB_LO_OFS, {16'h0, su[15:0]}, q);
        m.xfer(1'b0, sub_unit_pkg::SUB_HI_OFS, {16'h0, su[31:16]}, q);
        m.xfer(1'b0, sub_unit_pkg::FLAGS_OFS, {26'h0, fl}, q);
        m.xfer(1'b0, sub_unit_pkg::CTRL_OFS, {28'h0, edg, 1'b1, op}, q);
        m.xfer(1'b0, sub_unit_pkg::CTRL_OFS, 32'h0, q);
        m.xfer(1'b1, sub_unit_pkg::RES_LO_OFS, 32'h0, g_lo);
        m.xfer(1'b1, sub_unit_pkg::RES_HI_OFS, 32'h0, g_hi);
        m.xfer(1'b1, sub_unit_pkg::FLAGS_OFS, 32'h0, g_fl);
        m.xfer(1'b1, sub_unit_pkg::EXEC_CNT_OFS, 32'h0, g_cnt);
        exp_cnt = exp_cnt + (edg ? 16'h1 : 16'h3);
        chk("result low", {16'h0, exp_lo}, g_lo);
        chk("result high", {16'h0, exp_hi}, g_hi);
        chk("flags", {26'h0, exp_fl}, g_fl);
        chk("exec count", {16'h0, exp_cnt}, g_cnt);
        chk("result port", {exp_hi, exp_lo}, res);
        chk("flags port", {26'h0, exp_fl}, {26'h0, fo});
    endtask

    task automatic sc_sgn(input logic [31:0] mi, input logic [31:0] su, input logic b);
        logic [32:0] w;
        w = {1'b0, mi} - {1'b0, su} - {32'h0, b};
        exp_lo = w[15:0];
        exp_hi = w[31:16];
        exp_fl = {w[31], mi[31] & !su[31] & !w[31], !mi[31] & su[31] & w[31], w[32],
            w[31:0] == 32'h0, 1'b0};
        run(2'h0, mi, su, {3'h0, b, 2'h1}, 1'b1);
    endtask

    // Operands are kept decimal in the digits used unless an error case is meant
    task automatic sc_bcd(input logic dbl, input logic [31:0] mi, input logic [31:0] su);
        int n;
        logic bad;
        longint d;
        logic [31:0] r;
        n = dbl ? 8 : 4;
        bad = 1'b0;
        for (int i = 0; i < n; i++) bad |= (mi[4*i+:4] > 4'h9) || (su[4*i+:4] > 4'h9);
        exp_fl = {5'h1F, bad};
        if (!bad) begin
            d = dec(mi, n) - dec(su, n);
            exp_fl[2] = d < 0;
            if (d < 0) d += dbl ? 64'd100000000 : 64'd10000;
            r = bcd(d);
            exp_lo = r[15:0];
            if (dbl) exp_hi = r[31:16];
            exp_fl[1] = dbl ? r == 32'h0 : r[15:0] == 16'h0;
            exp_fl[0] = 1'b0;
        end
        run(dbl ? 2'h2 : 2'h1, mi, su, 6'h3E, 1'b1);
    endtask

    task automatic sc_regs;
        logic [31:0] q;
        logic [5:0] ofs [6] = '{sub_unit_pkg::CTRL_OFS, sub_unit_pkg::RES_LO_OFS,
            sub_unit_pkg::RES_HI_OFS, sub_unit_pkg::FLAGS_OFS, sub_unit_pkg::EXEC_CNT_OFS, 6'h24};
        foreach (ofs[i]) begin
            m.xfer(1'b1, ofs[i], 32'h0, q);
            chk("reset value", 32'h0, q);
        end
        m.xfer(1'b0, sub_unit_pkg::RES_LO_OFS, 32'h00001234, q);
        m.xfer(1'b1, sub_unit_pkg::RES_LO_OFS, 32'h0, q);
        chk("read-only result", 32'h0, q);
        m.xfer(1'b0, sub_unit_pkg::MIN_LO_OFS, 32'hFFFFFFFF, q);
        m.xfer(1'b1, sub_unit_pkg::MIN_LO_OFS, 32'h0, q);
        chk("operand width", 32'h0000FFFF, q);
    endtask

    initial begin
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        sc_regs();
        sc_sgn(32'h20F55A10, 32'hB8A360E3, 1'b0);
        sc_sgn(32'h7FFFFFFF, 32'hFFFFFFFF, 1'b0);
        sc_sgn(32'h7FFFFFFE, 32'hFFFFFFFF, 1'b1);
        sc_sgn(32'h80000000, 32'h00000001, 1'b0);
        sc_sgn(32'h80000001, 32'h00000001, 1'b1);
        sc_sgn(32'h00000001, 32'h00000000, 1'b1);
        sc_sgn(32'h00000000, 32'h00000000, 1'b1);
        sc_bcd(1'b0, 32'hFFFF0005, 32'h00000003);
        sc_bcd(1'b0, 32'h00000000, 32'h00007556);
        sc_bcd(1'b0, 32'h00001234, 32'h00001234);
        sc_bcd(1'b0, 32'h000012A4, 32'h00000001);
        sc_bcd(1'b0, 32'h00000001, 32'h000000F0);
        sc_bcd(1'b1, 32'h09583960, 32'h17072641);
        sc_bcd(1'b1, 32'h99999999, 32'h00000000);
        sc_bcd(1'b1, 32'h12345678, 32'h12345678);
        sc_bcd(1'b1, 32'h00000000, 32'hA0000000);
        exp_fl = 6'h00;
        run(2'h3, 32'h0, 32'h0, 6'h04, 1'b1);
        exp_lo = 16'h0002;
        exp_fl = 6'h38;
        run(2'h1, 32'h5, 32'h3, 6'h39, 1'b0);
        summarize();
    end
endmodule // testbench
